/* verilog/tmr_pkg.sv */
// Constants of the 16-bit event timer: register offsets, field positions,
// reset values and event action codes.
// Assumes a byte-wide register port with 8-bit byte offsets.
package tmr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_EVENT_CONTROL    = 8'h09;
    localparam logic [7:0] OFS_INTERRUPT_ENABLE = 8'h0a;
    localparam logic [7:0] OFS_INTERRUPT_FLAGS  = 8'h0b;
    localparam logic [7:0] OFS_DEBUG_CONTROL    = 8'h0e;
    localparam logic [7:0] OFS_SHARED_BYTE      = 8'h0f;
    localparam logic [7:0] OFS_COUNT_VALUE      = 8'h20;
    localparam logic [7:0] OFS_TOP_VALUE        = 8'h26;
    localparam logic [7:0] OFS_COMPARE_BASE     = 8'h28;
    localparam logic [7:0] OFS_COMPARE_STEP     = 8'h02;
    localparam logic [7:0] OFS_HIGH_BYTE        = 8'h01;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int POS_COUNT_ON_EVENT  = 0;
    localparam int POS_ACTION_LO       = 1;
    localparam int POS_ACTION_HI       = 2;
    localparam int POS_WRAP            = 0;
    localparam int POS_COMPARE_ZERO    = 4;
    localparam int POS_RUN_WHILE_HALT  = 0;
    localparam logic [7:0] FLAG_MASK   = 8'h71;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_COUNT   = 16'h0000;
    localparam logic [15:0] RST_TOP     = 16'hffff;
    localparam logic [15:0] RST_COMPARE = 16'h0000;

    // ------------------------------------------------------------------
    // Event actions
    // ------------------------------------------------------------------
    localparam logic [1:0] ACTION_RISING_EDGE      = 2'h0;
    localparam logic [1:0] ACTION_BOTH_EDGES       = 2'h1;
    localparam logic [1:0] ACTION_HIGH_LEVEL_GATE  = 2'h2;
    localparam logic [1:0] ACTION_DIRECTION_CONTROL = 2'h3;

endpackage

/* verilog/tmr_sync.sv */
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes an active-low asynchronous reset already released synchronously.
`timescale 1ns/1ns
module tmr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage_reg <= '0;
            sync_out  <= '0;
        end else begin
            stage_reg <= async_in;
            sync_out  <= stage_reg;
        end
    end
endmodule

/* verilog/tmr_cmp_chan.sv */
// One compare channel: 16-bit compare value and equality against the count.
// Assumes the caller assembles the 16-bit write from the shared byte latch.
`timescale 1ns/1ns
module tmr_cmp_chan (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        load_in,
    input  wire logic [15:0] load_value_in,
    input  wire logic [15:0] count_in,
    output logic      [15:0] compare_out,
    output logic             match_out
);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            compare_out <= tmr_pkg::RST_COMPARE;
        end else if (load_in) begin
            compare_out <= load_value_in;
        end
    end

    assign match_out = (count_in == compare_out);
endmodule

/* verilog/tmr_event_timer.sv */
// 16-bit timer/counter register slice: event counting, compare and wrap
// flags, debug halt, shared byte latch for 16-bit access.
// Assumes a byte-wide register port with one-cycle read/write strobes.
//
// Contract
// RULE1: Action 0 advances the counter once per rising event edge.
// RULE2: Action 1 advances the counter once per event edge, either way.
// RULE3: Action 2 counts on prescaled ticks only while event is high.
// RULE4: Action 3 counts ticks, up when event low, down when high.
// RULE5: Bit 0 of event control gates event counting on or off.
// RULE6: Interrupt enable bits 4..6 enable compare interrupts of channels 0..2.
// RULE7: Interrupt enable bit 0 enables the wrap interrupt.
// RULE8: Compare flag n sets whenever count equals compare n; bits 4..6.
// RULE9: Wrap flag bit 0 sets on reaching top or bottom.
// RULE10: Flags never clear by hardware; writing one clears only that bit.
// RULE11: Without run-while-halted, debug break halts counter and ignores events.
// RULE12: One 8-bit shared byte latch at 0x0f, read and write.
// RULE13: 16-bit registers: low byte at offset, high byte at offset plus one.
// RULE14: Bus write to the counter wins over an internal count update.
// RULE15: Counter at 0x20 resets to zero, fully read and write.
// RULE16: Top value register at 0x26 resets to 0xffff.
// RULE17: Low write goes to latch, high write commits; low read latches high.
// RULE18: Interrupt asserts while any flag and its enable are both set.
`timescale 1ns/1ns
module tmr_event_timer #(
    parameter int CHANNELS = 3
) (
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic [7:0] bus_addr_in,
    input  wire logic [7:0] bus_wdata_in,
    input  wire logic       bus_write_in,
    input  wire logic       bus_read_in,
    output logic      [7:0] bus_rdata_out,
    input  wire logic       count_enable_in,
    input  wire logic       prescale_tick_in,
    input  wire logic       event_in,
    input  wire logic       debug_halt_in,
    output logic      [15:0] count_out,
    output logic            irq_out
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]  event_control_reg;
    logic [7:0]  interrupt_enable_reg;
    logic [7:0]  interrupt_flags_reg;
    logic [7:0]  interrupt_flags_next;
    logic [7:0]  debug_control_reg;
    logic [7:0]  shared_byte_reg;
    logic [7:0]  shared_byte_next;
    logic [15:0] count_value_reg;
    logic [15:0] count_value_next;
    logic [15:0] top_value_reg;
    logic [7:0]  rdata_next;
    logic        event_prev_reg;
    logic        event_sync;

    logic [15:0] compare_value [CHANNELS];
    logic [CHANNELS-1:0] compare_match;
    logic [CHANNELS-1:0] compare_load;
    logic [CHANNELS-1:0] compare_lo_hit;
    logic [CHANNELS-1:0] compare_hi_hit;

    // ------------------------------------------------------------------
    // Event input synchroniser
    // ------------------------------------------------------------------
    tmr_sync #(
        .WIDTH (1)
    ) u_event_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n),
        .async_in (event_in),
        .sync_out (event_sync)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire wr_event_control = bus_write_in && (bus_addr_in == tmr_pkg::OFS_EVENT_CONTROL);
    wire wr_int_enable    = bus_write_in && (bus_addr_in == tmr_pkg::OFS_INTERRUPT_ENABLE);
    wire wr_int_flags     = bus_write_in && (bus_addr_in == tmr_pkg::OFS_INTERRUPT_FLAGS);
    wire wr_debug_control = bus_write_in && (bus_addr_in == tmr_pkg::OFS_DEBUG_CONTROL);
    wire wr_shared_byte   = bus_write_in && (bus_addr_in == tmr_pkg::OFS_SHARED_BYTE); // RULE12

    wire cnt_lo_hit = (bus_addr_in == tmr_pkg::OFS_COUNT_VALUE);
    wire cnt_hi_hit = (bus_addr_in == (tmr_pkg::OFS_COUNT_VALUE + tmr_pkg::OFS_HIGH_BYTE));
    wire top_lo_hit = (bus_addr_in == tmr_pkg::OFS_TOP_VALUE);
    wire top_hi_hit = (bus_addr_in == (tmr_pkg::OFS_TOP_VALUE + tmr_pkg::OFS_HIGH_BYTE));

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_cmp
            localparam logic [7:0] CMP_OFS = tmr_pkg::OFS_COMPARE_BASE
                                           + 8'(gi) * tmr_pkg::OFS_COMPARE_STEP;
            assign compare_lo_hit[gi] = (bus_addr_in == CMP_OFS);
            assign compare_hi_hit[gi] = (bus_addr_in == (CMP_OFS + tmr_pkg::OFS_HIGH_BYTE));
            assign compare_load[gi]   = bus_write_in && compare_hi_hit[gi]; // RULE17

            tmr_cmp_chan u_cmp (
                .clk_in        (clk_in),
                .rst_n_in      (rst_n),
                .load_in       (compare_load[gi]),
                .load_value_in ({bus_wdata_in, shared_byte_reg}),
                .count_in      (count_value_reg),
                .compare_out   (compare_value[gi]),
                .match_out     (compare_match[gi])
            );
        end
    endgenerate

    // Any low byte of a 16-bit register and the high byte that pairs with it
    wire        wide_lo_hit = cnt_lo_hit || top_lo_hit || (|compare_lo_hit); // RULE13
    wire        wide_hi_hit = cnt_hi_hit || top_hi_hit || (|compare_hi_hit); // RULE13
    wire        wr_cnt_hi   = bus_write_in && cnt_hi_hit;
    wire        wr_top_hi   = bus_write_in && top_hi_hit;
    wire [15:0] wide_value  = {bus_wdata_in, shared_byte_reg}; // RULE17

    logic [7:0] wide_hi_byte;
    always_comb begin
        wide_hi_byte = 8'h00;
        if (cnt_lo_hit) begin
            wide_hi_byte = count_value_reg[15:8];
        end else if (top_lo_hit) begin
            wide_hi_byte = top_value_reg[15:8];
        end
        for (int i = 0; i < CHANNELS; i++) begin
            if (compare_lo_hit[i]) begin
                wide_hi_byte = compare_value[i][15:8];
            end
        end
    end

    // ------------------------------------------------------------------
    // Count control
    // ------------------------------------------------------------------
    wire       count_on_event = event_control_reg[tmr_pkg::POS_COUNT_ON_EVENT];
    wire [1:0] event_action_select =
        event_control_reg[tmr_pkg::POS_ACTION_HI:tmr_pkg::POS_ACTION_LO];
    wire run_while_halted = debug_control_reg[tmr_pkg::POS_RUN_WHILE_HALT];
    wire halted           = debug_halt_in && !run_while_halted; // RULE11
    wire event_rise       = event_sync && !event_prev_reg;
    wire event_edge       = event_sync ^ event_prev_reg;

    logic step;
    logic count_down;
    always_comb begin
        step       = prescale_tick_in;
        count_down = 1'b0;
        if (count_on_event) begin // RULE5
            unique case (event_action_select)
                tmr_pkg::ACTION_RISING_EDGE: begin
                    step = event_rise; // RULE1
                end
                tmr_pkg::ACTION_BOTH_EDGES: begin
                    step = event_edge; // RULE2
                end
                tmr_pkg::ACTION_HIGH_LEVEL_GATE: begin
                    step = prescale_tick_in && event_sync; // RULE3
                end
                tmr_pkg::ACTION_DIRECTION_CONTROL: begin
                    step       = prescale_tick_in; // RULE4
                    count_down = event_sync; // RULE4
                end
            endcase
        end
    end

    wire advance   = count_enable_in && step && !halted; // RULE11
    wire at_top    = !count_down && (count_value_reg == top_value_reg);
    wire at_bottom = count_down && (count_value_reg == 16'h0000);
    wire wrap_set  = advance && (at_top || at_bottom); // RULE9

    logic [15:0] count_step;
    always_comb begin
        if (at_top) begin
            count_step = 16'h0000;
        end else if (at_bottom) begin
            count_step = top_value_reg;
        end else if (count_down) begin
            count_step = count_value_reg - 16'h0001;
        end else begin
            count_step = count_value_reg + 16'h0001;
        end
    end

    always_comb begin
        if (wr_cnt_hi) begin
            count_value_next = wide_value; // RULE14
        end else if (advance) begin
            count_value_next = count_step;
        end else begin
            count_value_next = count_value_reg;
        end
    end

    // ------------------------------------------------------------------
    // Flags, shared byte and read data
    // ------------------------------------------------------------------
    logic [7:0] flag_set;
    always_comb begin
        flag_set = 8'h00;
        flag_set[tmr_pkg::POS_WRAP] = wrap_set; // RULE9
        for (int i = 0; i < CHANNELS; i++) begin
            flag_set[tmr_pkg::POS_COMPARE_ZERO + i] = compare_match[i]; // RULE8
        end
    end

    wire [7:0] flag_clear = wr_int_flags ? bus_wdata_in : 8'h00;
    // Set beats a clear in the same cycle
    assign interrupt_flags_next = (flag_set | (interrupt_flags_reg & ~flag_clear))
                                & tmr_pkg::FLAG_MASK; // RULE10

    always_comb begin
        shared_byte_next = shared_byte_reg;
        if (wr_shared_byte || (bus_write_in && wide_lo_hit)) begin
            shared_byte_next = bus_wdata_in; // RULE17
        end else if (bus_read_in && wide_lo_hit) begin
            shared_byte_next = wide_hi_byte; // RULE17
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        if (bus_read_in) begin
            if (bus_addr_in == tmr_pkg::OFS_EVENT_CONTROL) begin
                rdata_next = event_control_reg;
            end else if (bus_addr_in == tmr_pkg::OFS_INTERRUPT_ENABLE) begin
                rdata_next = interrupt_enable_reg;
            end else if (bus_addr_in == tmr_pkg::OFS_INTERRUPT_FLAGS) begin
                rdata_next = interrupt_flags_reg;
            end else if (bus_addr_in == tmr_pkg::OFS_DEBUG_CONTROL) begin
                rdata_next = debug_control_reg;
            end else if (bus_addr_in == tmr_pkg::OFS_SHARED_BYTE || wide_hi_hit) begin
                rdata_next = shared_byte_reg; // RULE17
            end else if (cnt_lo_hit) begin
                rdata_next = count_value_reg[7:0];
            end else if (top_lo_hit) begin
                rdata_next = top_value_reg[7:0];
            end else begin
                for (int i = 0; i < CHANNELS; i++) begin
                    if (compare_lo_hit[i]) begin
                        rdata_next = compare_value[i][7:0];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            event_control_reg    <= tmr_pkg::RST_BYTE;
            interrupt_enable_reg <= tmr_pkg::RST_BYTE;
            interrupt_flags_reg  <= tmr_pkg::RST_BYTE;
            debug_control_reg    <= tmr_pkg::RST_BYTE;
            shared_byte_reg      <= tmr_pkg::RST_BYTE;
            count_value_reg      <= tmr_pkg::RST_COUNT; // RULE15
            top_value_reg        <= tmr_pkg::RST_TOP; // RULE16
            event_prev_reg       <= 1'b0;
            bus_rdata_out        <= 8'h00;
        end else begin
            if (wr_event_control) event_control_reg <= bus_wdata_in & 8'h07;
            if (wr_int_enable) interrupt_enable_reg <= bus_wdata_in & tmr_pkg::FLAG_MASK; // RULE6
            if (wr_debug_control) debug_control_reg <= bus_wdata_in & 8'h01;
            if (wr_top_hi) top_value_reg <= wide_value; // RULE16
            interrupt_flags_reg <= interrupt_flags_next;
            shared_byte_reg     <= shared_byte_next;
            count_value_reg     <= count_value_next;
            // Edges seen during a halt are swallowed, not replayed later
            event_prev_reg      <= event_sync;
            bus_rdata_out       <= rdata_next;
        end
    end

    assign count_out = count_value_reg;
    assign irq_out   = |(interrupt_flags_reg & interrupt_enable_reg); // RULE18 RULE7

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    sequence s_top_lo_write;
        bus_write_in && top_lo_hit;
    endsequence
    sequence s_top_hi_write;
        bus_write_in && top_hi_hit;
    endsequence

    wire no_bus_cnt = !wr_cnt_hi;

    chk_rise_step: assert property ( // RULE1
        count_on_event && event_action_select == tmr_pkg::ACTION_RISING_EDGE
        && count_enable_in && !halted && no_bus_cnt && event_rise && !at_top
        |=> count_value_reg == $past(count_value_reg) + 16'h0001)
        else $error("rising event did not advance counter");

    chk_both_edges: assert property ( // RULE2
        count_on_event && event_action_select == tmr_pkg::ACTION_BOTH_EDGES
        && count_enable_in && !halted && no_bus_cnt && $fell(event_sync) && !at_top
        |=> count_value_reg == $past(count_value_reg) + 16'h0001)
        else $error("falling event did not advance counter");

    chk_level_gate: assert property ( // RULE3
        count_on_event && event_action_select == tmr_pkg::ACTION_HIGH_LEVEL_GATE
        && !event_sync && no_bus_cnt
        |=> $stable(count_value_reg))
        else $error("counter moved while gate low");

    chk_down_count: assert property ( // RULE4
        count_on_event && event_action_select == tmr_pkg::ACTION_DIRECTION_CONTROL
        && event_sync && prescale_tick_in && count_enable_in && !halted
        && no_bus_cnt && count_value_reg != 16'h0000
        |=> count_value_reg == $past(count_value_reg) - 16'h0001)
        else $error("counter did not count down");

    chk_cmp_flag: assert property ( // RULE8
        compare_match[0] |=> interrupt_flags_reg[tmr_pkg::POS_COMPARE_ZERO])
        else $error("compare flag missed match");

    chk_wrap_top: assert property ( // RULE9
        advance && at_top && no_bus_cnt
        |=> count_value_reg == 16'h0000 && interrupt_flags_reg[tmr_pkg::POS_WRAP])
        else $error("wrap at top not taken");

    chk_flag_sticky: assert property ( // RULE10
        $fell(interrupt_flags_reg[tmr_pkg::POS_WRAP])
        |-> $past(wr_int_flags && bus_wdata_in[tmr_pkg::POS_WRAP]))
        else $error("wrap flag cleared without write");

    chk_debug_halt: assert property ( // RULE11
        halted && no_bus_cnt |=> $stable(count_value_reg))
        else $error("counter moved in debug halt");

    chk_bus_wins: assert property ( // RULE14
        wr_cnt_hi |=> count_value_reg == {$past(bus_wdata_in), $past(shared_byte_reg)})
        else $error("bus write to counter lost");

    chk_pair_commit: assert property ( // RULE17
        s_top_lo_write ##1 s_top_hi_write
        |=> top_value_reg == {$past(bus_wdata_in), $past(bus_wdata_in, 2)})
        else $error("16-bit top write not paired");

    chk_lo_latch: assert property ( // RULE17
        bus_read_in && !bus_write_in && cnt_lo_hit
        |=> shared_byte_reg == $past(count_value_reg[15:8]))
        else $error("low read did not latch high byte");

    chk_irq_wrap: assert property ( // RULE18
        interrupt_flags_reg[tmr_pkg::POS_WRAP]
        && interrupt_enable_reg[tmr_pkg::POS_WRAP] |-> irq_out)
        else $error("enabled wrap flag gave no interrupt");
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the event timer register slice.
// Assumes the timer package and design files are compiled before it.
`timescale 1ns/1ns
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e); end end
module tb_top;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [7:0]  bus_addr_in = 8'h00;
    logic [7:0]  bus_wdata_in = 8'h00;
    logic        bus_write_in = 1'b0;
    logic        bus_read_in = 1'b0;
    logic [7:0]  bus_rdata_out;
    logic        count_enable_in = 1'b0;
    logic        prescale_tick_in = 1'b0;
    logic        event_in = 1'b0;
    logic        debug_halt_in = 1'b0;
    logic [15:0] count_out;
    logic        irq_out;
    int          miscompares = 0;
    int          checks = 0;
    logic [7:0]  exp_q[$];
    logic [7:0]  mon_exp;
    logic        rd_seen = 1'b0;
    logic [7:0]  r8;
    logic [15:0] r16;
    logic [15:0] exp_a[4] = '{16'h0011, 16'h0011, 16'h0014, 16'h000c};
    logic [15:0] exp_b[4] = '{16'h0011, 16'h0012, 16'h0014, 16'h0010};

    always #5 clk_in = ~clk_in;

    tmr_event_timer uut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .bus_addr_in(bus_addr_in),
        .bus_wdata_in(bus_wdata_in), .bus_write_in(bus_write_in),
        .bus_read_in(bus_read_in), .bus_rdata_out(bus_rdata_out),
        .count_enable_in(count_enable_in), .prescale_tick_in(prescale_tick_in),
        .event_in(event_in), .debug_halt_in(debug_halt_in),
        .count_out(count_out), .irq_out(irq_out)
    );

    // ------------------------------------------------------------------
    // Read monitor: oldest expectation against the returned byte
    // ------------------------------------------------------------------
    always @(posedge clk_in) rd_seen <= bus_read_in;
    always @(negedge clk_in) begin
        if (rd_seen) begin
            mon_exp = exp_q.pop_front();
            `CHK(bus_rdata_out, mon_exp, "read data")
        end
    end

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_addr_in = a;
        bus_wdata_in = d;
        bus_write_in = 1'b1;
        @(negedge clk_in);
        bus_write_in = 1'b0;
        @(negedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus_addr_in = a;
        bus_read_in = 1'b1;
        exp_q.push_back(e);
        @(negedge clk_in);
        bus_read_in = 1'b0;
        @(negedge clk_in);
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        bus_addr_in = a;
        bus_wdata_in = d[7:0];
        bus_write_in = 1'b1;
        @(negedge clk_in);
        bus_addr_in = a + 8'h01;
        bus_wdata_in = d[15:8];
        @(negedge clk_in);
        bus_write_in = 1'b0;
        @(negedge clk_in);
    endtask
    task automatic rd16(input logic [7:0] a, input logic [15:0] e);
        rd(a, e[7:0]);
        rd(a + 8'h01, e[15:8]);
    endtask
    task automatic run(input int n, input logic tk);
        prescale_tick_in = tk;
        repeat (n) @(negedge clk_in);
        prescale_tick_in = 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'hff25));
        repeat (5) @(negedge clk_in);
        reset_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        rd(8'h09, 8'h00);
        rd(8'h0a, 8'h00);
        rd(8'h0b, 8'h70);
        rd(8'h0e, 8'h00);
        rd(8'h0f, 8'h00);
        rd16(8'h20, 16'h0000);
        rd16(8'h26, 16'hffff);
        rd(8'h30, 8'h00);
        `CHK(irq_out, 1'b0, "irq after reset")
        r8 = 8'($urandom);
        wr(8'h0f, r8);
        rd(8'h0f, r8);
        r16 = 16'($urandom);
        wr16(8'h26, r16);
        rd16(8'h26, r16);
        for (int n = 0; n < 3; n++) wr16(8'h28 + 8'(2 * n), 16'h0200 + 16'(n));
        wr(8'h0b, 8'h10);
        rd(8'h0b, 8'h60);
        wr(8'h0b, 8'h60);
        rd(8'h0b, 8'h00);
        for (int n = 0; n < 3; n++) begin
            wr16(8'h20, 16'h0200 + 16'(n));
            rd(8'h0b, 8'h10 << n);
            wr16(8'h20, 16'h0000);
            wr(8'h0b, 8'h70);
        end
        wr16(8'h26, 16'h0004);
        count_enable_in = 1'b1;
        run(5, 1'b1);
        rd16(8'h20, 16'h0000);
        rd(8'h0b, 8'h01);
        wr(8'h0a, 8'h20);
        `CHK(irq_out, 1'b0, "irq other enable")
        wr(8'h0a, 8'h01);
        `CHK(irq_out, 1'b1, "irq wrap enable")
        wr(8'h0b, 8'h01);
        `CHK(irq_out, 1'b0, "irq after clear")
        wr16(8'h26, 16'hffff);
        for (int a = 0; a < 4; a++) begin
            wr(8'h09, {5'h00, 2'(a), 1'b1});
            wr16(8'h20, 16'h0010);
            event_in = 1'b1;
            run(5, 1'b0);
            run(4, 1'b1);
            rd16(8'h20, exp_a[a]);
            event_in = 1'b0;
            run(5, 1'b0);
            run(4, 1'b1);
            rd16(8'h20, exp_b[a]);
        end
        wr(8'h09, 8'h00);
        wr16(8'h20, 16'h0000);
        event_in = 1'b1;
        run(5, 1'b0);
        `CHK(count_out, 16'h0000, "event moved counter")
        event_in = 1'b0;
        run(5, 1'b0);
        debug_halt_in = 1'b1;
        run(3, 1'b1);
        rd16(8'h20, 16'h0000);
        wr(8'h0e, 8'h01);
        run(3, 1'b1);
        rd16(8'h20, 16'h0003);
        `CHK(count_out, 16'h0003, "count after halt run")
        prescale_tick_in = 1'b1;
        wr16(8'h20, 16'h1234);
        prescale_tick_in = 1'b0;
        rd16(8'h20, 16'h1235);
        repeat (2) @(negedge clk_in);
        stop_test();
    end
endmodule
